// *** rtl/alarm_flag_latch.sv ***
// Overview of operation
// - raw bit 15 set while any bit of safety words two or three is set
// - raw bit 14 set while any bit of safety word one is set
// - raw bit 13 set when an enabled permanent-failure fault triggers
// - raw bit 12 set when a safety alert also enabled in its mask triggers
// - raw bit 11 set when a failure alert also enabled in its mask triggers
// - raw bit 10 sets shortly after reset, marking that initialization began
// - raw bit 9 sets after initialization once the first adc pass completed
// - raw bit 7 sets after first full loop and then stays set
// - latched bit 7 sets on every full loop completion when enabled
// - raw bit 6 high while the charge switch is off
// - raw bit 5 high while the discharge switch is off
// - raw bit 4 high while stack voltage is below shutdown threshold
// - raw bit 3 high while fuse is driven by device or secondary protector
// - raw bit 2 high while cell balancing is active
// - raw bit 1 sets after first adc pass and then stays set
// - latched bit 1 sets on every adc pass when enabled
// - raw bit 0 set when the device wakes from sleep
// - raw word is readable unlatched and selectable for latching and alert
// - enable mask gates latching; host may rewrite it at any time
// - enable mask loads the default alarm mask at reset
// - alert output is driven from the latched word
// - writing one clears a latched bit unless its event sets it again in that cycle; only those bits clear
// - enabled raw flag other than bits 7 and 1 sets and holds its latched bit
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps

module alarm_flag_latch
  import alarm_flag_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire alarm_src_t            src,
  input  wire logic [FLAG_W-1:0]     default_alarm_mask,
  output logic                       alert,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  function automatic reg_sel_t decode(input logic [AXI_ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    case (a)
      OFS_LATCHED:   s = SEL_LATCHED;
      OFS_UNLATCHED: s = SEL_UNLATCHED;
      OFS_MASK:      s = SEL_MASK;
      default:       s = SEL_NONE;
    endcase
    return s;
  endfunction

  // only the two low byte lanes carry flag bits
  function automatic logic [FLAG_W-1:0] lanes(input logic [3:0] st);
    return {{8{st[1]}}, {8{st[0]}}};
  endfunction

  logic [FLAG_W-1:0]     latched_reg;
  logic [FLAG_W-1:0]     latched_next;
  logic [FLAG_W-1:0]     raw_reg;
  logic [FLAG_W-1:0]     raw_next;
  logic [FLAG_W-1:0]     mask_reg;
  logic [FLAG_W-1:0]     event_vec;
  logic [FLAG_W-1:0]     set_vec;
  logic [FLAG_W-1:0]     clr_vec;
  logic                  init_begun_reg;
  logic                  init_done_reg;
  logic                  full_loop_seen_reg;
  logic                  adc_pass_seen_reg;
  logic                  alert_reg;
  wr_state_t             wr_state_reg;
  rd_state_t             rd_state_reg;
  logic                  aw_got_reg;
  logic                  w_got_reg;
  logic [AXI_ADDR_W-1:0] waddr_reg;
  logic [FLAG_W-1:0]     wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  awready_reg;
  logic                  wready_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [1:0]            rresp_reg;
  logic                  wr_fire;
  reg_sel_t              wr_sel;

  assign wr_fire = (wr_state_reg == WR_IDLE) && aw_got_reg && w_got_reg;
  assign wr_sel  = decode(waddr_reg);

  // progress flags are sticky until the next reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      init_begun_reg     <= 1'b0;
      init_done_reg      <= 1'b0;
      full_loop_seen_reg <= 1'b0;
      adc_pass_seen_reg  <= 1'b0;
    end
    else
    begin
      init_begun_reg <= 1'b1;
      if (init_begun_reg && src.adc_pass_pulse)
        init_done_reg <= 1'b1;
      if (src.full_loop_pulse)
        full_loop_seen_reg <= 1'b1;
      if (src.adc_pass_pulse)
        adc_pass_seen_reg <= 1'b1;
    end
  end

  always_comb
  begin
    raw_next                  = FLAGS_RESET;
    raw_next[BIT_SAFETY_BC]   = |src.safety_b || |src.safety_c;
    raw_next[BIT_SAFETY_A]    = |src.safety_a;
    raw_next[BIT_PF_FLAG]     = |(src.pf_fault & src.pf_fault_en);
    raw_next[BIT_SF_ALERT]    = |(src.sf_alert & src.sf_alert_mask);
    raw_next[BIT_PF_ALERT]    = |(src.pf_alert & src.pf_alert_mask);
    raw_next[BIT_INIT_BEGUN]  = init_begun_reg;
    raw_next[BIT_INIT_DONE]   = init_done_reg;
    raw_next[BIT_FULL_LOOP]   = full_loop_seen_reg;
    raw_next[BIT_CHG_OFF]     = !src.charge_switch;
    raw_next[BIT_DSG_OFF]     = !src.discharge_switch;
    raw_next[BIT_STACK_LOW]   = src.stack_voltage < src.shutdown_stack_voltage;
    raw_next[BIT_FUSE]        = src.fuse_drive_self || src.fuse_drive_secondary;
    raw_next[BIT_BALANCING]   = src.balancing_active;
    raw_next[BIT_ADC_PASS]    = adc_pass_seen_reg;
    raw_next[BIT_WAKE]        = src.wake_pulse;
  end

  // scan bits latch per completion, not from the sticky raw copy
  always_comb
  begin
    event_vec                = raw_next;
    event_vec[BIT_FULL_LOOP] = src.full_loop_pulse;
    event_vec[BIT_ADC_PASS]  = src.adc_pass_pulse;
    set_vec                  = event_vec & mask_reg & RESERVED_ZERO_KEEP;
    clr_vec                  = FLAGS_RESET;
    if (wr_fire && wr_sel == SEL_LATCHED)
      clr_vec = wdata_reg & lanes(wstrb_reg);
    // a new event in the clearing cycle keeps its bit
    latched_next = ((latched_reg & ~clr_vec) | set_vec) & RESERVED_ZERO_KEEP;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latched_reg <= FLAGS_RESET;
      raw_reg     <= FLAGS_RESET;
      alert_reg   <= 1'b0;
    end
    else
    begin
      latched_reg <= latched_next;
      raw_reg     <= raw_next & RESERVED_ZERO_KEEP;
      alert_reg   <= |latched_next;
    end
  end

  // reset is synchronous, so the strap level is caught on a clock edge
  always_ff @(posedge clk)
  begin
    if (rst)
      mask_reg <= default_alarm_mask & RESERVED_ZERO_KEEP;
    else if (wr_fire && wr_sel == SEL_MASK)
      mask_reg <= ((mask_reg & ~lanes(wstrb_reg)) | (wdata_reg & lanes(wstrb_reg)))
                  & RESERVED_ZERO_KEEP;
  end

  // address and data may arrive in either order; each is held until both are in
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_state_reg <= WR_IDLE;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= FLAGS_RESET;
      wstrb_reg    <= 4'h0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_reg)
        WR_IDLE:
        begin
          if (s_axi_awvalid && awready_reg)
          begin
            aw_got_reg  <= 1'b1;
            waddr_reg   <= s_axi_awaddr;
            awready_reg <= 1'b0;
          end
          else if (!aw_got_reg)
            awready_reg <= 1'b1;
          if (s_axi_wvalid && wready_reg)
          begin
            w_got_reg  <= 1'b1;
            wdata_reg  <= s_axi_wdata[FLAG_W-1:0];
            wstrb_reg  <= s_axi_wstrb;
            wready_reg <= 1'b0;
          end
          else if (!w_got_reg)
            wready_reg <= 1'b1;
          if (wr_fire)
          begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            bvalid_reg   <= 1'b1;
            bresp_reg    <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            wr_state_reg <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
          begin
            bvalid_reg   <= 1'b0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            wr_state_reg <= WR_IDLE;
          end
        end
        default:
        begin
          wr_state_reg <= WR_IDLE;
          aw_got_reg   <= 1'b0;
          w_got_reg    <= 1'b0;
          bvalid_reg   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
    end
    else
    begin
      case (rd_state_reg)
        RD_IDLE:
        begin
          if (s_axi_arvalid && arready_reg)
          begin
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b1;
            rresp_reg    <= RESP_OKAY;
            rd_state_reg <= RD_DATA;
            case (decode(s_axi_araddr))
              SEL_LATCHED:   rdata_reg <= {16'h0000, latched_reg};
              SEL_UNLATCHED: rdata_reg <= {16'h0000, raw_reg};
              SEL_MASK:      rdata_reg <= {16'h0000, mask_reg};
              default:
              begin
                rdata_reg <= '0;
                rresp_reg <= RESP_SLVERR;
              end
            endcase
          end
          else
            arready_reg <= 1'b1;
        end
        RD_DATA:
        begin
          if (s_axi_rready)
          begin
            rvalid_reg   <= 1'b0;
            arready_reg  <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default:
        begin
          rd_state_reg <= RD_IDLE;
          rvalid_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign alert         = alert_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  a_safety_bc_raw: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> raw_reg[BIT_SAFETY_BC] == ($past(|src.safety_b) || $past(|src.safety_c)))
    else $error("raw bit 15 does not follow safety words two and three");

  a_stack_low_raw: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |->
      raw_reg[BIT_STACK_LOW] == $past(src.stack_voltage < src.shutdown_stack_voltage))
    else $error("raw bit 4 does not follow stack voltage compare");

  a_init_order: assert property (@(posedge clk) disable iff (rst)
    raw_reg[BIT_INIT_DONE] |-> raw_reg[BIT_INIT_BEGUN])
    else $error("init done raised before init begun");

  a_init_begun_soon: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##2 raw_reg[BIT_INIT_BEGUN])
    else $error("init begun flag late after reset");

  a_scan_sticky: assert property (@(posedge clk) disable iff (rst)
    raw_reg[BIT_ADC_PASS] |=> raw_reg[BIT_ADC_PASS])
    else $error("adc pass raw flag dropped");

  a_latch_sets: assert property (@(posedge clk) disable iff (rst)
    (set_vec != FLAGS_RESET) |=> (latched_reg & $past(set_vec)) == $past(set_vec))
    else $error("enabled event did not latch");

  a_latch_holds: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (latched_reg & $past(latched_reg & ~clr_vec)) == $past(latched_reg & ~clr_vec))
    else $error("latched bit cleared without a one written");

  a_w1c_clears: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && wr_sel == SEL_LATCHED) |=> (latched_reg & $past(clr_vec & ~set_vec)) == 16'h0000)
    else $error("written one did not clear latched bit");

  a_alert_tracks: assert property (@(posedge clk) disable iff (rst)
    alert_reg == (latched_reg != FLAGS_RESET))
    else $error("alert disagrees with latched word");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    !latched_reg[8] && !raw_reg[8] && !mask_reg[8])
    else $error("reserved bit 8 is set");

  a_mask_default: assert property (@(posedge clk)
    $fell(rst) |-> mask_reg == ($past(default_alarm_mask) & RESERVED_ZERO_KEEP))
    else $error("mask not loaded from default after reset");

  a_write_resp: assert property (@(posedge clk) disable iff (rst)
    wr_fire |=> s_axi_bvalid ##0 (wr_state_reg == WR_RESP))
    else $error("write response missing");

endmodule

// *** rtl/alarm_flag_pkg.sv ***
package alarm_flag_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int FLAG_W     = 16;
  localparam int SAFETY_W   = 8;
  localparam int SF_ALERT_W = 24;
  localparam int PF_ALERT_W = 32;
  localparam int PF_FAULT_W = 32;
  localparam int VOLT_W     = 16;

  localparam logic [AXI_ADDR_W-1:0] OFS_LATCHED   = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_UNLATCHED = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_MASK      = 8'h08;

  // bit 8 is the reserved_zero position in all three words
  localparam logic [FLAG_W-1:0] RESERVED_ZERO_KEEP = 16'hFEFF;
  localparam logic [FLAG_W-1:0] FLAGS_RESET        = 16'h0000;

  localparam int BIT_SAFETY_BC    = 15;
  localparam int BIT_SAFETY_A     = 14;
  localparam int BIT_PF_FLAG      = 13;
  localparam int BIT_SF_ALERT     = 12;
  localparam int BIT_PF_ALERT     = 11;
  localparam int BIT_INIT_BEGUN   = 10;
  localparam int BIT_INIT_DONE    = 9;
  localparam int BIT_FULL_LOOP    = 7;
  localparam int BIT_CHG_OFF      = 6;
  localparam int BIT_DSG_OFF      = 5;
  localparam int BIT_STACK_LOW    = 4;
  localparam int BIT_FUSE         = 3;
  localparam int BIT_BALANCING    = 2;
  localparam int BIT_ADC_PASS     = 1;
  localparam int BIT_WAKE         = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SAFETY_W-1:0]   safety_a;
    logic [SAFETY_W-1:0]   safety_b;
    logic [SAFETY_W-1:0]   safety_c;
    logic [PF_FAULT_W-1:0] pf_fault;
    logic [PF_FAULT_W-1:0] pf_fault_en;
    logic [SF_ALERT_W-1:0] sf_alert;
    logic [SF_ALERT_W-1:0] sf_alert_mask;
    logic [PF_ALERT_W-1:0] pf_alert;
    logic [PF_ALERT_W-1:0] pf_alert_mask;
    logic                  adc_pass_pulse;
    logic                  full_loop_pulse;
    logic                  charge_switch;
    logic                  discharge_switch;
    logic [VOLT_W-1:0]     stack_voltage;
    logic [VOLT_W-1:0]     shutdown_stack_voltage;
    logic                  fuse_drive_self;
    logic                  fuse_drive_secondary;
    logic                  balancing_active;
    logic                  wake_pulse;
  } alarm_src_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_t;

  typedef enum logic [1:0] {
    SEL_NONE      = 2'h0,
    SEL_LATCHED   = 2'h1,
    SEL_UNLATCHED = 2'h2,
    SEL_MASK      = 2'h3
  } reg_sel_t;

endpackage

// *** test/alert_host_model.sv ***
`timescale 1ns/100ps

// host side: counts alert assertions so the bench can tell one alarm episode from two
module alert_host_model
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic alert,
  output int        rise_count
);
  logic alert_prev;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alert_prev <= 1'b0;
      rise_count <= 0;
    end
    else
    begin
      alert_prev <= alert;
      if (alert && !alert_prev)
        rise_count <= rise_count + 1;
    end
  end
endmodule

// *** test/alarm_flag_latch_bench.sv ***
`timescale 1ns/100ps

module alarm_flag_latch_bench
  import alarm_flag_pkg::*;
;
  logic                  clk;
  logic                  rst;
  alarm_src_t            src;
  logic [FLAG_W-1:0]     default_alarm_mask;
  logic                  alert;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata;
  logic [3:0]            wstrb;
  logic [3:0]            strb;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  int                    miscompares;
  int                    check_count;
  int                    cycles;
  int                    rise_count;
  logic [15:0]           acc;
  logic [15:0]           exp_tab [0:14] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0008, 16'h0004, 16'h0000, 16'h0000,
    16'h0000};

  alarm_flag_latch i_alarm_flag_latch
  (
    .clk                (clk),
    .rst                (rst),
    .src                (src),
    .default_alarm_mask (default_alarm_mask),
    .alert              (alert),
    .s_axi_awaddr       (awaddr),
    .s_axi_awvalid      (awvalid),
    .s_axi_awready      (awready),
    .s_axi_wdata        (wdata),
    .s_axi_wstrb        (wstrb),
    .s_axi_wvalid       (wvalid),
    .s_axi_wready       (wready),
    .s_axi_bresp        (bresp),
    .s_axi_bvalid       (bvalid),
    .s_axi_bready       (bready),
    .s_axi_araddr       (araddr),
    .s_axi_arvalid      (arvalid),
    .s_axi_arready      (arready),
    .s_axi_rdata        (rdata),
    .s_axi_rresp        (rresp),
    .s_axi_rvalid       (rvalid),
    .s_axi_rready       (rready)
  );

  alert_host_model i_alert_host_model
  (
    .clk        (clk),
    .rst        (rst),
    .alert      (alert),
    .rise_count (rise_count)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a hang anywhere in the handshake loops ends here
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    int   n;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    {awaddr, wdata, wstrb} <= {a, d, strb};
    {awvalid, wvalid, bready} <= 3'h7;
    while ((aw || w) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (aw && awready === 1'b1)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    chk({30'h00000000, bresp}, {30'h00000000, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h00000000, rresp}, {30'h00000000, er});
  endtask

  // entries 12 to 14 sit just outside their condition and must leave the raw word alone
  task automatic set_src(input int i, input logic on);
    case (i)
      0: src.safety_b <= on ? 8'h01 : 8'h00;
      1: src.safety_c <= on ? 8'h80 : 8'h00;
      2: src.safety_a <= on ? 8'h10 : 8'h00;
      3: src.pf_fault <= on ? 32'h00000001 : 32'h00000000;
      4: src.sf_alert <= on ? 24'h800000 : 24'h000000;
      5: src.pf_alert <= on ? 32'h00010000 : 32'h00000000;
      6: src.charge_switch <= !on;
      7: src.discharge_switch <= !on;
      8: src.stack_voltage <= on ? 16'h07FF : 16'h1000;
      9: src.fuse_drive_self <= on;
      10: src.fuse_drive_secondary <= on;
      11: src.balancing_active <= on;
      12: src.stack_voltage <= on ? 16'h0800 : 16'h1000;
      13: src.pf_fault <= on ? 32'h00000002 : 32'h00000000;
      default: src.sf_alert <= on ? 24'h000001 : 24'h000000;
    endcase
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: src.adc_pass_pulse <= 1'b1;
      1: src.full_loop_pulse <= 1'b1;
      default: src.wake_pulse <= 1'b1;
    endcase
    @(posedge clk);
    {src.adc_pass_pulse, src.full_loop_pulse, src.wake_pulse} <= 3'h0;
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    src = '0;
    src.charge_switch = 1'b1;
    src.discharge_switch = 1'b1;
    src.stack_voltage = 16'h1000;
    src.shutdown_stack_voltage = 16'h0800;
    src.pf_fault_en = 32'h00000001;
    src.sf_alert_mask = 24'h800000;
    src.pf_alert_mask = 32'h00010000;
    default_alarm_mask = 16'hFFFF;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, wstrb, araddr} = '0;
    strb = 4'hF;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_MASK, 32'h0000FEFF, RESP_OKAY);
    rd(OFS_UNLATCHED, 32'h00000400, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000400, RESP_OKAY);
    chk({31'h00000000, alert}, 32'h00000001);
    wr(OFS_MASK, 32'h0000F87C, RESP_OKAY);
    wr(OFS_LATCHED, 32'h0000FFFF, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000000, RESP_OKAY);
    chk({31'h00000000, alert}, 32'h00000000);
    acc = 16'h0000;
    for (int i = 0; i < 15; i++)
    begin
      set_src(i, 1'b1);
      repeat (3) @(posedge clk);
      rd(OFS_UNLATCHED, {16'h0000, 16'h0400 | exp_tab[i]}, RESP_OKAY);
      set_src(i, 1'b0);
      acc = acc | exp_tab[i];
      repeat (3) @(posedge clk);
      rd(OFS_LATCHED, {16'h0000, acc}, RESP_OKAY);
    end
    chk({31'h00000000, alert}, 32'h00000001);
    wr(OFS_LATCHED, 32'h0000807C, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00007800, RESP_OKAY);
    wr(OFS_LATCHED, 32'h00007800, RESP_OKAY);
    chk({31'h00000000, alert}, 32'h00000000);
    // scan flags: raw word is sticky, latched word follows each completion only while its bit is enabled in the mask
    pulse(0);
    rd(OFS_UNLATCHED, 32'h00000602, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000000, RESP_OKAY);
    wr(OFS_MASK, 32'h00000082, RESP_OKAY);
    pulse(0);
    rd(OFS_LATCHED, 32'h00000002, RESP_OKAY);
    wr(OFS_LATCHED, 32'h00000002, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000000, RESP_OKAY);
    pulse(1);
    rd(OFS_UNLATCHED, 32'h00000682, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000080, RESP_OKAY);
    wr(OFS_LATCHED, 32'h00000080, RESP_OKAY);
    pulse(1);
    rd(OFS_LATCHED, 32'h00000080, RESP_OKAY);
    wr(OFS_MASK, 32'h00000080, RESP_OKAY);
    wr(OFS_LATCHED, 32'h00000080, RESP_OKAY);
    pulse(0);
    rd(OFS_LATCHED, 32'h00000000, RESP_OKAY);
    wr(OFS_MASK, 32'h00000100, RESP_OKAY);
    rd(OFS_MASK, 32'h00000000, RESP_OKAY);
    // only byte lane 0 enabled: the upper flag byte must keep its old value
    strb = 4'h1;
    wr(OFS_MASK, 32'h0000FFFF, RESP_OKAY);
    rd(OFS_MASK, 32'h000000FF, RESP_OKAY);
    strb = 4'hF;
    wr(OFS_UNLATCHED, 32'h0000FFFF, RESP_OKAY);
    rd(OFS_UNLATCHED, 32'h00000682, RESP_OKAY);
    wr(8'h0C, 32'h0000FFFF, RESP_SLVERR);
    rd(8'h0C, 32'h00000000, RESP_SLVERR);
    // second reset with a different default mask
    @(posedge clk);
    rst <= 1'b1;
    default_alarm_mask <= 16'h0100;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_MASK, 32'h00000000, RESP_OKAY);
    rd(OFS_UNLATCHED, 32'h00000400, RESP_OKAY);
    wr(OFS_MASK, 32'h00000001, RESP_OKAY);
    pulse(2);
    rd(OFS_LATCHED, 32'h00000001, RESP_OKAY);
    chk(rise_count, 1);
    wr(OFS_LATCHED, 32'h00000001, RESP_OKAY);
    rd(OFS_LATCHED, 32'h00000000, RESP_OKAY);
    chk({31'h00000000, alert}, 32'h00000000);
    pulse(2);
    chk(rise_count, 2);
    test_done();
  end
endmodule
